// File: src/sbst_tap.sv
`timescale 1ns/10ps
`default_nettype none

module sbst_tap
	import sbst_pkg::*;
#(
	parameter logic [2:0] REV_CODE = 3'h0, // Arbitrary value
	parameter logic [16:0] DEV_CODE = 17'h00001, // Arbitrary value
	parameter logic [10:0] MFR_CODE = 11'h001 // Arbitrary value
) (
	// System clock, reset and enable
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic ce,
	// Test port pins
	input wire logic scan_tck,
	input wire logic scan_tms,
	input wire logic scan_tms_driven,
	input wire logic scan_tdi,
	input wire logic scan_tdi_driven,
	output logic scan_tdo,
	output logic scan_tdo_oe,
	// Package pad states in exit order
	input wire logic [SBST_BSR_W-1:0] pad_in,
	// Pin control towards the memory core
	output logic core_drive_en,
	output logic core_force_hiz,
	output logic [SBST_BSR_W-1:0] core_drive_data
);

	// ==========================================================
	// Decoding helpers

	// Data register chosen by an instruction; reserved codes fall back to bypass
	function automatic sbst_path_e path_of(input logic [2:0] ins);
		sbst_path_e p;
		p = SBST_PATH_BYP;
		unique case (ins)
			SBST_INS_EXTEST: p = SBST_PATH_BSR;
			SBST_INS_IDCODE: p = SBST_PATH_ID;
			SBST_INS_SAMPLE_Z: p = SBST_PATH_BSR;
			SBST_INS_SAMPLE_PRE: p = SBST_PATH_BSR;
			SBST_INS_BYPASS: p = SBST_PATH_BYP;
			default: p = SBST_PATH_BYP;
		endcase
		return p;
	endfunction : path_of

	// Pin control that an instruction applies to the memory core
	function automatic sbst_mode_s mode_of(input logic [2:0] ins);
		sbst_mode_s m;
		m.drive_en = (ins == SBST_INS_EXTEST);
		m.force_hiz = (ins == SBST_INS_SAMPLE_Z);
		return m;
	endfunction : mode_of

	// Fixed identification word
	function automatic logic [SBST_ID_W-1:0] id_word();
		logic [SBST_ID_W-1:0] w;
		w = '0;
		w[SBST_ID_REV_HI:SBST_ID_REV_LO] = REV_CODE;
		w[SBST_ID_DEV_HI:SBST_ID_DEV_LO] = DEV_CODE;
		w[SBST_ID_MFR_HI:SBST_ID_MFR_LO] = MFR_CODE;
		w[SBST_ID_PRESENT] = SBST_ID_PRESENT_VAL;
		return w;
	endfunction : id_word

	// ==========================================================
	// Test clock domain state
	sbst_state_e state_r, state_nxt;
	logic [SBST_IR_W-1:0] ir_r, ir_nxt;
	logic [SBST_IR_W-1:0] ir_sh_r, ir_sh_nxt;
	logic byp_r, byp_nxt;
	logic [SBST_ID_W-1:0] id_r, id_nxt;
	logic [SBST_BSR_W-1:0] bsr_r, bsr_nxt;
	logic [SBST_BSR_W-1:0] upd_r, upd_nxt;
	logic upd_tgl_r, upd_tgl_nxt;
	sbst_mode_s mode_r, mode_nxt;
	logic [SBST_BSR_W-1:0] pad_s1_r, pad_s2_r;
	logic tdo_r, tdo_nxt;
	logic tdo_oe_r, tdo_oe_nxt;

	logic tms_eff;
	logic tdi_eff;
	sbst_path_e path;
	logic [SBST_BSR_W-1:0] pad_cap;

	// Floating pins behave as pulled high
	assign tms_eff = scan_tms_driven ? scan_tms : 1'b1;
	assign tdi_eff = scan_tdi_driven ? scan_tdi : 1'b1;
	assign path = path_of(ir_r);

	// Captured pad states, with the internal cell at its fixed level
	always_comb begin
		pad_cap = pad_s2_r;
		pad_cap[SBST_INTERNAL_CELL] = SBST_INTERNAL_VAL;
	end

	// ==========================================================
	// Controller state moves on rising test clock
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SBST_TLR: begin
				state_nxt = tms_eff ? SBST_TLR : SBST_RTI;
			end
			SBST_RTI: begin
				state_nxt = tms_eff ? SBST_SEL_DR : SBST_RTI;
			end
			SBST_SEL_DR: begin
				state_nxt = tms_eff ? SBST_SEL_IR : SBST_CAP_DR;
			end
			SBST_CAP_DR: begin
				state_nxt = tms_eff ? SBST_EX1_DR : SBST_SH_DR;
			end
			SBST_SH_DR: begin
				state_nxt = tms_eff ? SBST_EX1_DR : SBST_SH_DR;
			end
			SBST_EX1_DR: begin
				state_nxt = tms_eff ? SBST_UPD_DR : SBST_PAU_DR;
			end
			SBST_PAU_DR: begin
				state_nxt = tms_eff ? SBST_EX2_DR : SBST_PAU_DR;
			end
			SBST_EX2_DR: begin
				state_nxt = tms_eff ? SBST_UPD_DR : SBST_SH_DR;
			end
			SBST_UPD_DR: begin
				state_nxt = tms_eff ? SBST_SEL_DR : SBST_RTI;
			end
			SBST_SEL_IR: begin
				state_nxt = tms_eff ? SBST_TLR : SBST_CAP_IR;
			end
			SBST_CAP_IR: begin
				state_nxt = tms_eff ? SBST_EX1_IR : SBST_SH_IR;
			end
			SBST_SH_IR: begin
				state_nxt = tms_eff ? SBST_EX1_IR : SBST_SH_IR;
			end
			SBST_EX1_IR: begin
				state_nxt = tms_eff ? SBST_UPD_IR : SBST_PAU_IR;
			end
			SBST_PAU_IR: begin
				state_nxt = tms_eff ? SBST_EX2_IR : SBST_PAU_IR;
			end
			SBST_EX2_IR: begin
				state_nxt = tms_eff ? SBST_UPD_IR : SBST_SH_IR;
			end
			SBST_UPD_IR: begin
				state_nxt = tms_eff ? SBST_SEL_DR : SBST_RTI;
			end
		endcase
	end

	// ==========================================================
	// Instruction and data registers, next values
	always_comb begin
		ir_nxt = ir_r;
		ir_sh_nxt = ir_sh_r;
		byp_nxt = byp_r;
		id_nxt = id_r;
		bsr_nxt = bsr_r;
		upd_nxt = upd_r;
		upd_tgl_nxt = upd_tgl_r;
		unique case (state_r)
			SBST_TLR: begin
				ir_nxt = SBST_IR_RESET;
			end
			SBST_CAP_IR: begin
				ir_sh_nxt = SBST_IR_CAPTURE;
			end
			SBST_SH_IR: begin
				ir_sh_nxt = {tdi_eff, ir_sh_r[SBST_IR_W-1:1]};
			end
			SBST_UPD_IR: begin
				ir_nxt = ir_sh_r;
				// A newly chosen bypass starts from a cleared cell
				if (path_of(ir_sh_r) == SBST_PATH_BYP) begin
					byp_nxt = SBST_BYP_CLEAR;
				end
			end
			SBST_CAP_DR: begin
				unique case (path)
					SBST_PATH_BSR: bsr_nxt = pad_cap;
					SBST_PATH_ID: id_nxt = id_word();
					SBST_PATH_BYP: byp_nxt = SBST_BYP_CLEAR;
					default: byp_nxt = SBST_BYP_CLEAR;
				endcase
			end
			SBST_SH_DR: begin
				unique case (path)
					SBST_PATH_BSR: bsr_nxt = {tdi_eff, bsr_r[SBST_BSR_W-1:1]};
					SBST_PATH_ID: id_nxt = {tdi_eff, id_r[SBST_ID_W-1:1]};
					SBST_PATH_BYP: byp_nxt = tdi_eff;
					default: byp_nxt = tdi_eff;
				endcase
			end
			SBST_UPD_DR: begin
				// Boundary chain contents reach the pin drivers
				if (path == SBST_PATH_BSR) begin
					upd_nxt = bsr_r;
					upd_tgl_nxt = ~upd_tgl_r;
				end
			end
			default: begin
				ir_nxt = ir_r;
			end
		endcase
		// A new instruction's pin control rides the same toggle as the update word
		if (mode_of(ir_nxt) != mode_r) begin
			upd_tgl_nxt = ~upd_tgl_r;
		end
	end

	// Pin control takes effect at the edge that loads the instruction
	always_comb begin
		mode_nxt = mode_of(ir_nxt);
	end

	// Registers on the rising test clock
	always_ff @(posedge scan_tck or posedge reset) begin
		if (reset) begin
			state_r <= SBST_TLR;
			ir_r <= SBST_IR_RESET;
			ir_sh_r <= '0;
			byp_r <= SBST_BYP_CLEAR;
			id_r <= '0;
			bsr_r <= '0;
			upd_r <= '0;
			upd_tgl_r <= 1'b0;
			mode_r <= '0;
			pad_s1_r <= '0;
			pad_s2_r <= '0;
		end else begin
			state_r <= state_nxt;
			ir_r <= ir_nxt;
			ir_sh_r <= ir_sh_nxt;
			byp_r <= byp_nxt;
			id_r <= id_nxt;
			bsr_r <= bsr_nxt;
			upd_r <= upd_nxt;
			upd_tgl_r <= upd_tgl_nxt;
			mode_r <= mode_nxt;
			pad_s1_r <= pad_in; // Pads cross into the test clock
			pad_s2_r <= pad_s1_r;
		end
	end

	// ==========================================================
	// Serial output, next value
	always_comb begin
		tdo_nxt = tdo_r;
		tdo_oe_nxt = 1'b0;
		if (state_r == SBST_SH_IR) begin
			tdo_nxt = ir_sh_r[0];
			tdo_oe_nxt = 1'b1;
		end else if (state_r == SBST_SH_DR) begin
			tdo_oe_nxt = 1'b1;
			unique case (path)
				SBST_PATH_BSR: tdo_nxt = bsr_r[0];
				SBST_PATH_ID: tdo_nxt = id_r[0];
				SBST_PATH_BYP: tdo_nxt = byp_r;
				default: tdo_nxt = byp_r;
			endcase
		end
	end

	// Serial output changes on the falling test clock
	always_ff @(negedge scan_tck or posedge reset) begin
		if (reset) begin
			tdo_r <= 1'b0;
			tdo_oe_r <= 1'b0;
		end else begin
			tdo_r <= tdo_nxt;
			tdo_oe_r <= tdo_oe_nxt;
		end
	end

	assign scan_tdo = tdo_r;
	assign scan_tdo_oe = tdo_oe_r;

	// ==========================================================
	// System clock side: one toggle handshake carries update word and pin control
	sbst_mode_s core_mode_r, core_mode_nxt;
	logic tgl_s1_r, tgl_s1_nxt;
	logic tgl_s2_r, tgl_s2_nxt;
	logic tgl_s3_r, tgl_s3_nxt;
	logic [SBST_BSR_W-1:0] drv_r, drv_nxt;

	// Word and mode are stable long before their toggle is seen here
	always_comb begin
		core_mode_nxt = core_mode_r;
		tgl_s1_nxt = tgl_s1_r;
		tgl_s2_nxt = tgl_s2_r;
		tgl_s3_nxt = tgl_s3_r;
		drv_nxt = drv_r;
		if (ce) begin
			tgl_s1_nxt = upd_tgl_r;
			tgl_s2_nxt = tgl_s1_r;
			tgl_s3_nxt = tgl_s2_r;
			if (tgl_s2_r != tgl_s3_r) begin
				drv_nxt = upd_r;
				core_mode_nxt = mode_r; // Both bits land together
			end
		end
	end

	// Registers on the system clock
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			core_mode_r <= '0;
			tgl_s1_r <= 1'b0;
			tgl_s2_r <= 1'b0;
			tgl_s3_r <= 1'b0;
			drv_r <= '0;
		end else begin
			core_mode_r <= core_mode_nxt;
			tgl_s1_r <= tgl_s1_nxt;
			tgl_s2_r <= tgl_s2_nxt;
			tgl_s3_r <= tgl_s3_nxt;
			drv_r <= drv_nxt;
		end
	end

	// Core controls straight from flip-flops
	assign core_drive_en = core_mode_r.drive_en;
	assign core_force_hiz = core_mode_r.force_hiz;
	assign core_drive_data = drv_r;

endmodule : sbst_tap

`default_nettype wire

// File: src/sbst_pkg.sv
// ==========================================================
// Constants and types of the boundary-scan test port
package sbst_pkg;

	// ==========================================================
	// Register widths
	localparam int SBST_IR_W = 3;
	localparam int SBST_ID_W = 32;
	localparam int SBST_BSR_W = 107;

	// ==========================================================
	// Instruction codes
	localparam logic [2:0] SBST_INS_EXTEST = 3'h0;
	localparam logic [2:0] SBST_INS_IDCODE = 3'h1;
	localparam logic [2:0] SBST_INS_SAMPLE_Z = 3'h2;
	localparam logic [2:0] SBST_INS_SAMPLE_PRE = 3'h4;
	localparam logic [2:0] SBST_INS_BYPASS = 3'h7;
	// Fixed pattern loaded into the instruction shifter on capture
	localparam logic [2:0] SBST_IR_CAPTURE = 3'h1;
	// Instruction after power-up and in test-logic-reset
	localparam logic [2:0] SBST_IR_RESET = SBST_INS_IDCODE;

	// ==========================================================
	// Identification register field positions
	localparam int SBST_ID_REV_HI = 31;
	localparam int SBST_ID_REV_LO = 29;
	localparam int SBST_ID_DEV_HI = 28;
	localparam int SBST_ID_DEV_LO = 12;
	localparam int SBST_ID_MFR_HI = 11;
	localparam int SBST_ID_MFR_LO = 1;
	localparam int SBST_ID_PRESENT = 0;
	localparam logic SBST_ID_PRESENT_VAL = 1'b1;

	// ==========================================================
	// Boundary chain: zero-based index of the cell tied to no pin
	localparam int SBST_INTERNAL_CELL = 47;
	localparam logic SBST_INTERNAL_VAL = 1'b0;
	// Value of the bypass cell on capture and on selecting bypass
	localparam logic SBST_BYP_CLEAR = 1'b0;

	// ==========================================================
	// Controller states
	typedef enum logic [3:0] {
		SBST_TLR, SBST_RTI, SBST_SEL_DR, SBST_CAP_DR, SBST_SH_DR, SBST_EX1_DR, SBST_PAU_DR, SBST_EX2_DR,
		SBST_UPD_DR, SBST_SEL_IR, SBST_CAP_IR, SBST_SH_IR, SBST_EX1_IR, SBST_PAU_IR, SBST_EX2_IR, SBST_UPD_IR
	} sbst_state_e;

	// Data register between the serial pins
	typedef enum logic [1:0] {
		SBST_PATH_BSR, SBST_PATH_ID, SBST_PATH_BYP
	} sbst_path_e;

	// Pin control handed to the memory core
	typedef struct packed {
		logic drive_en;
		logic force_hiz;
	} sbst_mode_s;

endpackage : sbst_pkg

// File: tb/sbst_tap_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Protocol checks at the test port
module sbst_tap_monitor
	import sbst_pkg::*;
(
	// System clock, reset and enable
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic ce,
	// Test port
	input wire logic scan_tck,
	input wire logic scan_tms,
	input wire logic scan_tms_driven,
	input wire logic scan_tdo,
	input wire logic scan_tdo_oe,
	// Core side
	input wire logic core_drive_en,
	input wire logic core_force_hiz,
	input wire logic [SBST_BSR_W-1:0] core_drive_data
);
	// Mode select as the controller sees it
	logic tms_eff;
	assign tms_eff = scan_tms | ~scan_tms_driven;

	// ==========
	// Link domain
	tlr_oe_a: assert property (@(posedge scan_tck) disable iff (reset) tms_eff [*5] |=> !scan_tdo_oe)
		else $error("output enable high after five mode-select ones");
	oe_rise_a: assert property (@(posedge scan_tck) disable iff (reset) $rose(scan_tdo_oe) |-> !$past(tms_eff))
		else $error("shift entered without mode-select low");
	oe_fall_a: assert property (@(posedge scan_tck) disable iff (reset) $fell(scan_tdo_oe) |-> $past(tms_eff))
		else $error("shift left without mode-select high");

	// ==========
	// System domain
	mode_excl_a: assert property (@(posedge sys_clk) disable iff (reset)
		!(core_drive_en && core_force_hiz))
		else $error("drive and high impedance both active");
	ce_freeze_a: assert property (@(posedge sys_clk) disable iff (reset)
		!ce |=> $stable(core_drive_en) && $stable(core_force_hiz) && $stable(core_drive_data))
		else $error("core outputs moved with enable low");
	tdo_edge_a: assert property (@(posedge sys_clk) disable iff (reset) $changed(scan_tdo) |-> !scan_tck)
		else $error("serial output changed with test clock high");
	oe_edge_a: assert property (@(posedge sys_clk) disable iff (reset) $changed(scan_tdo_oe) |-> !scan_tck)
		else $error("output enable changed with test clock high");
	tdo_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
		!scan_tdo_oe && !$past(scan_tdo_oe) |-> $stable(scan_tdo))
		else $error("serial output moved outside shift");

	// Main scenarios reached
	cov_drive_c: cover property (@(posedge sys_clk) $rose(core_drive_en));
	cov_hiz_c: cover property (@(posedge sys_clk) $rose(core_force_hiz));
	cov_shift_c: cover property (@(posedge scan_tck) $rose(scan_tdo_oe));
endmodule : sbst_tap_monitor
`default_nettype wire

// File: tb/sbst_jtag_host.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Behavioural external test controller
module sbst_jtag_host (
	// Test port pins
	output logic tck,
	output logic tms,
	output logic tms_drv,
	output logic tdi,
	output logic tdi_drv,
	input wire logic tdo
);
	// Idle pins: clock held low, serial input released
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tms_drv = 1'b1;
		tdi = 1'b0;
		tdi_drv = 1'b0;
	end

	// One test clock period, serial output taken at the rising edge
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#24 tck = 1'b1;
		q = tdo;
		#24 tck = 1'b0;
	endtask : step

	// Five periods with mode select undriven, then idle
	task automatic to_reset();
		logic q;
		tms_drv = 1'b0;
		repeat (5) step(1'b0, tdi, q);
		tms_drv = 1'b1;
		step(1'b0, tdi, q);
	endtask : to_reset

	// Full shift of n bits from idle back to idle
	task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
		logic q;
		dout = '0;
		step(1'b1, tdi, q);
		if (ir) step(1'b1, tdi, q);
		step(1'b0, tdi, q);
		step(1'b0, tdi, q);
		tdi_drv = 1'b1;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		tdi_drv = 1'b0;
		tdi = ~din[n-1]; // Released line shows the inverse
		step(1'b1, tdi, q);
		step(1'b0, tdi, q);
	endtask : scan
endmodule : sbst_jtag_host
`default_nettype wire

// File: tb/sbst_tap_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Testbench of the boundary-scan test port
module sbst_tap_tb
	import sbst_pkg::*;
;
	localparam logic [2:0] REV_C = 3'h5; // Arbitrary value
	localparam logic [16:0] DEV_C = 17'h0A5C3; // Arbitrary value
	localparam logic [10:0] MFR_C = 11'h2B4; // Arbitrary value
	logic sys_clk, reset, ce, scan_tck, scan_tms, scan_tms_driven, scan_tdi, scan_tdi_driven;
	logic scan_tdo, scan_tdo_oe, core_drive_en, core_force_hiz;
	logic [SBST_BSR_W-1:0] pad_in, core_drive_data, pad_exp;
	logic [127:0] din, dout;
	int err_total, n_tests, cyc;

	sbst_tap #(.REV_CODE(REV_C), .DEV_CODE(DEV_C), .MFR_CODE(MFR_C)) uut (.sys_clk, .reset, .ce, .scan_tck,
		.scan_tms, .scan_tms_driven, .scan_tdi, .scan_tdi_driven, .scan_tdo, .scan_tdo_oe, .pad_in,
		.core_drive_en, .core_force_hiz, .core_drive_data);
	sbst_jtag_host host (.tck(scan_tck), .tms(scan_tms), .tms_drv(scan_tms_driven), .tdi(scan_tdi),
		.tdi_drv(scan_tdi_driven), .tdo(scan_tdo));

	// System clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Cut a hang short
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_sys(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : wait_sys

	// ==========
	// Scenarios
	task automatic t_idcode();
		host.to_reset();
		din = {4{32'hC3A5_0F96}};
		host.scan(1'b0, 64, din, dout);
		chk(dout[31:0], {REV_C, DEV_C, MFR_C, SBST_ID_PRESENT_VAL});
		chk(dout[63:32], din[31:0]);
		chk({core_drive_en, core_force_hiz}, 2'h0);
		$display("identification test done");
	endtask : t_idcode

	task automatic t_bypass();
		host.scan(1'b1, 3, {125'h0, SBST_INS_BYPASS}, dout);
		chk(dout[2:0], SBST_IR_CAPTURE);
		host.scan(1'b0, 8, din, dout);
		chk(dout[7:0], {din[6:0], SBST_BYP_CLEAR});
		$display("bypass test done");
	endtask : t_bypass

	task automatic t_bscan();
		logic [2:0] codes [3] = '{SBST_INS_EXTEST, SBST_INS_SAMPLE_Z, SBST_INS_SAMPLE_PRE};
		logic [1:0] modes [3] = '{2'h2, 2'h1, 2'h0};
		for (int k = 0; k < 3; k++) begin
			host.scan(1'b1, 3, {125'h0, codes[k]}, dout);
			wait_sys(6);
			chk({core_drive_en, core_force_hiz}, modes[k]);
			din = {4{32'h96E1_3C5A}} << k;
			host.scan(1'b0, 108, din, dout);
			chk(dout[106:0], pad_exp);
			chk(dout[107], din[0]);
			wait_sys(6);
			chk(core_drive_data, din[107:1]);
		end
		$display("boundary test done");
	endtask : t_bscan

	task automatic t_freeze();
		logic [SBST_BSR_W-1:0] held;
		wait_sys(1);
		held = core_drive_data;
		ce = 1'b0;
		din = ~din;
		host.scan(1'b0, 107, din, dout);
		wait_sys(6);
		chk(core_drive_data, held);
		ce = 1'b1;
		wait_sys(6);
		chk(core_drive_data, din[106:0]);
		$display("enable test done");
	endtask : t_freeze

	task automatic t_reset();
		host.scan(1'b1, 3, {125'h0, SBST_INS_EXTEST}, dout);
		wait_sys(6);
		chk({core_drive_en, core_force_hiz}, 2'h2);
		reset = 1'b1;
		wait_sys(2);
		reset = 1'b0;
		chk({core_drive_en, core_force_hiz}, 2'h0);
		chk(core_drive_data, 128'h0);
		wait_sys(2);
		host.to_reset();
		host.scan(1'b0, 32, din, dout);
		chk(dout[31:0], {REV_C, DEV_C, MFR_C, SBST_ID_PRESENT_VAL});
		$display("reset test done");
	endtask : t_reset

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict

	// Main sequence
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		pad_in = 107'h5_A3C6_E1F0_9B2D_4C87_3E5A_1F6D;
		pad_in[SBST_INTERNAL_CELL] = 1'b1;
		pad_exp = pad_in;
		pad_exp[SBST_INTERNAL_CELL] = SBST_INTERNAL_VAL;
		repeat (6) @(posedge sys_clk);
		#1 reset = 1'b0;
		wait_sys(2);
		t_idcode();
		t_bypass();
		t_bscan();
		t_freeze();
		t_reset();
		give_verdict();
	end
endmodule : sbst_tap_tb

bind sbst_tap sbst_tap_monitor mon (.sys_clk, .reset, .ce, .scan_tck, .scan_tms, .scan_tms_driven, .scan_tdo,
	.scan_tdo_oe, .core_drive_en, .core_force_hiz, .core_drive_data);
`default_nettype wire
